// ---- design/frame_shifter.sv ----
/*
  Secondary-frame shifter: raises a frame request, then exchanges one
  16-bit control word MSB first, one bit per bitTick.
  Assumes bitTick and secFrameStart are synchronous one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_shifter (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // Word side
  input  wire logic        start,
  input  wire logic [15:0] word,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdData,
  // Link side
  output logic             fcReq,
  input  wire logic        secFrameStart,
  input  wire logic        bitTick,
  output logic             serOut,
  input  wire logic        serIn
);
  import sample_clock_pkg::*;

  logic [15:0] shift_r;
  logic [3:0]  bitCnt_r;
  logic        pend_r;
  logic        act_r;
  logic        done_r;
  wire         lastBit = act_r && bitTick && (bitCnt_r == 4'hF);

  always_ff @(posedge clock) begin
    if (srst) begin
      shift_r  <= 16'h0000;
      bitCnt_r <= 4'h0;
      pend_r   <= 1'b0;
      act_r    <= 1'b0;
      done_r   <= 1'b0;
    end else if (clkEn) begin
      done_r <= lastBit;
      if (start && !pend_r && !act_r) begin
        shift_r <= word;
        pend_r  <= 1'b1;
      end else if (pend_r && secFrameStart) begin
        pend_r   <= 1'b0;
        act_r    <= 1'b1;
        bitCnt_r <= 4'h0;
      end else if (act_r && bitTick) begin
        shift_r  <= {shift_r[14:0], serIn};
        bitCnt_r <= bitCnt_r + 4'h1;
        act_r    <= !lastBit;
      end
    end
  end

  assign busy   = pend_r || act_r || done_r;
  assign done   = done_r;
  assign rdData = shift_r[7:0];
  assign fcReq  = pend_r;
  assign serOut = shift_r[FRAME_BITS-1];

endmodule : frame_shifter
`default_nettype wire

// ---- design/sample_clock_host.sv ----
/*
  Host-side sequencer that programs the two-stage sample clock generator
  and the power modes of a line access device over secondary frames.
  Assumes the device pins are synchronous to clock and the device itself
  supplies frame and bit timing.
*/
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Host picks first stage to give a 36.864 MHz base.
// - Host uses the fixed second-stage pairs for the standard modem rates.
// - Host writes the divider then at once the multiplier, nothing between.
// - Ratio bit acts at the next index 9 write; host sets it first.
// - With ratio bit one, host writes a non-zero second stage.
// - Host keeps master clock over divider at 144 kHz or more.
// - Host programs first stage once, later only writes index 9; the code also accepts init again in normal mode.
// - Normal mode only after a valid sample-rate setting.
// - Sleep needs non-zero indices 7, 8, 9, then power value 0x08.
// - Wake by a low reset-pin pulse, then reprogram registers.
// - Deep sleep: write zero to index 9, then 0x18 to index 6.
// - After lock wait, host writes 0x80 to index 6.
// - One register per frame: read bit, 5-bit address, 8-bit data.
module sample_clock_host #(
  parameter int LOCK_WAIT  = sample_clock_pkg::LOCK_CYCLES,
  parameter int MCLK_KHZ   = sample_clock_pkg::MCLK_KHZ_DEFAULT
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic                    clkEn,
  // Command port
  input  wire logic                    cmdValid,
  output logic                         cmdReady,
  input  wire sample_clock_pkg::op_e   cmdOp,
  input  wire logic [7:0]              cmdFirstDiv,
  input  wire logic [7:0]              cmdFirstMult,
  input  wire logic                    cmdRatioSelect,
  input  wire logic [2:0]              cmdRate,
  input  wire logic [4:0]              cmdAddr,
  // Status
  output logic                         donePulse,
  output logic                         errPulse,
  output logic [7:0]                   rdData,
  output sample_clock_pkg::mode_e      mode,
  output logic                         settingValid,
  // Device pins
  output logic                         resetPinN,
  output logic                         fcReq,
  input  wire logic                    secFrameStart,
  input  wire logic                    bitTick,
  output logic                         serOut,
  input  wire logic                    serIn
);
  import sample_clock_pkg::*;

  state_e      state_r, state_nxt;
  op_e         op_r;
  mode_e       mode_r;
  logic [7:0]  firstDiv_r, firstMult_r, secondRatio_r, rdData_r;
  logic [4:0]  rdAddr_r;
  logic        ratioSel_r, issued_r, valid_r, done_r, err_r, rstPin_r;
  logic [19:0] cnt_r;
  logic        shBusy, shDone;
  logic [7:0]  shRd;

  // Command legality
  wire         accept   = cmdValid && (state_r == ST_IDLE);
  wire         asleep   = (mode_r == MODE_SLEEP) || (mode_r == MODE_DEEP);
  wire [7:0]   rateVal  = rate_byte(cmdRate);
  wire         rateOk   = (rateVal != 8'h00);
  wire         updOk    = MCLK_KHZ >= UPDATE_MIN_KHZ * (int'(cmdFirstDiv) + 1);
  wire         regsNz   = (firstDiv_r != 8'h00) && (firstMult_r != 8'h00)
                          && (secondRatio_r != 8'h00);
  wire         legal    =
      (cmdOp == OP_INIT)  ? (!asleep && updOk && rateOk) :
      (cmdOp == OP_RATE)  ? (!asleep && valid_r && rateOk) :
      (cmdOp == OP_SLEEP) ? (!asleep && valid_r && regsNz) :
      (cmdOp == OP_DEEP)  ? (mode_r != MODE_DEEP) :
      (cmdOp == OP_WAKE)  ? asleep :
      (cmdOp == OP_READ)  ? !asleep : 1'b0;
  wire         goStart  = accept && legal;

  // Frame word for the current write or read state
  wire         isWrite  = (state_r == ST_DIV) || (state_r == ST_MULT) ||
                          (state_r == ST_CGM) || (state_r == ST_RATIO) ||
                          (state_r == ST_POWER);
  wire [4:0]   wrAddr   =
      (state_r == ST_DIV)   ? REG_FIRST_DIV :
      (state_r == ST_MULT)  ? REG_FIRST_MULT :
      (state_r == ST_CGM)   ? REG_RATIO_SELECT :
      (state_r == ST_RATIO) ? REG_SECOND_RATIO : REG_POWER_MODE;
  wire [7:0]   pwrVal   = (op_r == OP_INIT)  ? PWR_NORMAL_VAL :
                          (op_r == OP_SLEEP) ? PWR_SLEEP_VAL : PWR_DEEP_VAL;
  wire [7:0]   wrData   =
      (state_r == ST_DIV)   ? firstDiv_r :
      (state_r == ST_MULT)  ? firstMult_r :
      (state_r == ST_CGM)   ? {7'h00, ratioSel_r} :
      (state_r == ST_RATIO) ? secondRatio_r : pwrVal;
  wire [15:0]  frameWord = (state_r == ST_READ) ?
      (16'h8000 | ({11'h000, rdAddr_r} << FRAME_ADDR_LSB)) :
      (({11'h000, wrAddr} << FRAME_ADDR_LSB) | {8'h00, wrData});
  wire         shStart  = (isWrite || state_r == ST_READ) && !issued_r
                          && !shBusy;
  wire         lockEnd  = (cnt_r == 20'h00000);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (goStart) begin
          case (cmdOp)
            OP_INIT:  state_nxt = ST_DIV;
            OP_RATE:  state_nxt = ST_RATIO;
            OP_SLEEP: state_nxt = ST_POWER;
            OP_DEEP:  state_nxt = ST_RATIO;
            OP_WAKE:  state_nxt = ST_RSTP;
            default:  state_nxt = ST_READ;
          endcase
        end
      end
      ST_DIV:   if (shDone) state_nxt = ST_MULT;
      ST_MULT:  if (shDone) state_nxt = ST_CGM;
      ST_CGM:   if (shDone) state_nxt = ST_RATIO;
      ST_RATIO: begin
        if (shDone) state_nxt = (op_r == OP_DEEP) ? ST_POWER : ST_LOCK;
      end
      ST_LOCK: begin
        if (lockEnd) state_nxt = (op_r == OP_INIT) ? ST_POWER : ST_IDLE;
      end
      ST_POWER: if (shDone) state_nxt = ST_IDLE;
      ST_RSTP:  if (lockEnd) state_nxt = ST_IDLE;
      ST_READ:  if (shDone) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer and shadows
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r       <= ST_IDLE;
      op_r          <= OP_INIT;
      mode_r        <= MODE_RESET;
      firstDiv_r    <= 8'h00;
      firstMult_r   <= 8'h00;
      secondRatio_r <= 8'h00;
      ratioSel_r    <= 1'b0;
      rdAddr_r      <= 5'h00;
      issued_r      <= 1'b0;
      valid_r       <= 1'b0;
      cnt_r         <= 20'h00000;
      done_r        <= 1'b0;
      err_r         <= 1'b0;
      rstPin_r      <= 1'b1;
      rdData_r      <= 8'h00;
    end else if (clkEn) begin
      state_r  <= state_nxt;
      issued_r <= (state_nxt == state_r) && (issued_r || shStart);
      done_r   <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
      err_r    <= accept && !legal;
      if (cnt_r != 20'h00000) cnt_r <= cnt_r - 20'h00001;
      if (goStart) begin
        op_r     <= cmdOp;
        rdAddr_r <= cmdAddr;
        if (cmdOp == OP_INIT) begin
          firstDiv_r  <= cmdFirstDiv;
          firstMult_r <= cmdFirstMult;
          ratioSel_r  <= cmdRatioSelect;
        end
        if (cmdOp == OP_INIT || cmdOp == OP_RATE) begin
          secondRatio_r <= rateVal;
          valid_r       <= 1'b0;
        end
        if (cmdOp == OP_DEEP) secondRatio_r <= 8'h00;
        if (cmdOp == OP_WAKE) begin
          cnt_r    <= 20'(RST_PULSE_CYCLES);
          rstPin_r <= 1'b0;
        end
      end
      if (state_r == ST_RATIO && shDone && op_r != OP_DEEP)
        cnt_r <= 20'(LOCK_WAIT);
      if (state_r == ST_LOCK && lockEnd) valid_r <= 1'b1;
      if (state_r == ST_POWER && shDone) begin
        mode_r <= (op_r == OP_INIT)  ? MODE_NORMAL :
                  (op_r == OP_SLEEP) ? MODE_SLEEP : MODE_DEEP;
      end
      if (state_r == ST_RSTP && lockEnd) begin
        rstPin_r <= 1'b1;
        mode_r   <= MODE_RESET;
        valid_r  <= 1'b0;
      end
      if (state_r == ST_READ && shDone) rdData_r <= shRd;
    end
  end

  frame_shifter u_shift (
    .clock         (clock),
    .srst          (srst),
    .clkEn         (clkEn),
    .start         (shStart),
    .word          (frameWord),
    .busy          (shBusy),
    .done          (shDone),
    .rdData        (shRd),
    .fcReq         (fcReq),
    .secFrameStart (secFrameStart),
    .bitTick       (bitTick),
    .serOut        (serOut),
    .serIn         (serIn)
  );

  assign cmdReady     = (state_r == ST_IDLE);
  assign donePulse    = done_r;
  assign errPulse     = err_r;
  assign rdData       = rdData_r;
  assign mode         = mode_r;
  assign settingValid = valid_r;
  assign resetPinN    = rstPin_r;

  default clocking cb @(posedge clock iff clkEn); endclocking
  default disable iff (srst);

  divMultOrder_a: assert property (
    state_r == ST_DIV && shDone |=> state_r == ST_MULT ##0 !issued_r)
    else $error("multiplier write did not follow divider");
  cgmFirst_a: assert property (
    state_r == ST_CGM && shDone |=> state_r == ST_RATIO)
    else $error("second stage write not after ratio bit");
  ratioNonzero_a: assert property (
    state_r == ST_RATIO && op_r != OP_DEEP |-> secondRatio_r != 8'h00)
    else $error("zero second stage written outside deep sleep");
  sleepRegs_a: assert property (
    state_r == ST_POWER && op_r == OP_SLEEP
      |-> firstDiv_r != 8'h00 && firstMult_r != 8'h00
          && secondRatio_r != 8'h00 && wrData == PWR_SLEEP_VAL)
    else $error("sleep entered with zero clock registers");
  deepOff_a: assert property (
    state_r == ST_POWER && op_r == OP_DEEP
      |-> secondRatio_r == 8'h00 && wrData == PWR_DEEP_VAL)
    else $error("deep sleep without second stage off");
  lockPower_a: assert property (
    state_r == ST_LOCK && lockEnd && op_r == OP_INIT
      |=> state_r == ST_POWER && wrData == PWR_NORMAL_VAL && valid_r)
    else $error("normal power value not written after lock");
  normalValid_a: assert property (
    $rose(mode_r == MODE_NORMAL) |-> valid_r)
    else $error("normal mode without valid setting");
  wakePulse_a: assert property (
    $fell(rstPin_r) |-> !rstPin_r [*8] ##0 (state_r == ST_RSTP))
    else $error("reset pin pulse too short");
  frameFormat_a: assert property (
    shStart |-> frameWord[14:13] == 2'b00
      && frameWord[FRAME_RW_POS] == (state_r == ST_READ))
    else $error("malformed secondary frame word");
  updateRate_a: assert property (
    state_r == ST_DIV
      |-> MCLK_KHZ >= UPDATE_MIN_KHZ * (int'(firstDiv_r) + 1))
    else $error("first stage update rate below minimum");

endmodule : sample_clock_host
`default_nettype wire

// ---- inc/sample_clock_pkg.sv ----
/*
  Constants, encodings and the modem rate table shared by the sample-clock
  and power-mode host controller and its serial frame shifter.
  Assumes a 250 MHz system clock and a device with 8-bit control registers.
*/
package sample_clock_pkg;

  // Device register indices
  localparam logic [4:0] REG_POWER_MODE    = 5'h06;
  localparam logic [4:0] REG_FIRST_DIV     = 5'h07;
  localparam logic [4:0] REG_FIRST_MULT    = 5'h08;
  localparam logic [4:0] REG_SECOND_RATIO  = 5'h09;
  localparam logic [4:0] REG_RATIO_SELECT  = 5'h0A;

  // Power mode values and bit positions
  localparam int         MAIN_PDN_POS      = 3;
  localparam int         LINK_PDN_POS      = 4;
  localparam logic [7:0] PWR_NORMAL_VAL    = 8'h80;
  localparam logic [7:0] PWR_SLEEP_VAL     = 8'h08;
  localparam logic [7:0] PWR_DEEP_VAL      = 8'h18;

  // Secondary frame word layout
  localparam int         FRAME_BITS        = 16;
  localparam int         FRAME_RW_POS      = 15;
  localparam int         FRAME_ADDR_LSB    = 8;

  // Timing
  localparam int         CLOCK_MHZ         = 250;
  localparam int         LOCK_MAX_US       = 1000;
  localparam int         LOCK_CYCLES       = LOCK_MAX_US * CLOCK_MHZ;
  localparam int         RST_PULSE_NS      = 1000;
  localparam int         RST_PULSE_CYCLES  = RST_PULSE_NS * CLOCK_MHZ / 1000;
  localparam int         UPDATE_MIN_KHZ    = 144;
  localparam int         MCLK_KHZ_DEFAULT  = 48000;

  typedef enum logic [2:0] {
    OP_INIT  = 3'h0,
    OP_RATE  = 3'h1,
    OP_SLEEP = 3'h2,
    OP_DEEP  = 3'h3,
    OP_WAKE  = 3'h4,
    OP_READ  = 3'h5
  } op_e;

  typedef enum logic [1:0] {
    MODE_RESET  = 2'h0,
    MODE_NORMAL = 2'h1,
    MODE_SLEEP  = 2'h2,
    MODE_DEEP   = 2'h3
  } mode_e;

  // Gray codes along init: idle, div, mult, cgm, ratio, lock, power
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_DIV   = 4'h1,
    ST_MULT  = 4'h3,
    ST_CGM   = 4'h2,
    ST_RATIO = 4'h6,
    ST_LOCK  = 4'h7,
    ST_POWER = 4'h5,
    ST_RSTP  = 4'hC,
    ST_READ  = 4'h8
  } state_e;

  // Second stage {div-1, mult-1}; 7 is unused
  localparam logic [7:0] RATE_7200  = 8'h11;
  localparam logic [7:0] RATE_8000  = 8'h89;
  localparam logic [7:0] RATE_8229  = 8'h67;
  localparam logic [7:0] RATE_8400  = 8'h56;
  localparam logic [7:0] RATE_9000  = 8'h34;
  localparam logic [7:0] RATE_9600  = 8'h23;
  localparam logic [7:0] RATE_10286 = 8'h69;

  function automatic logic [7:0] rate_byte(input logic [2:0] sel);
    case (sel)
      3'h0:    rate_byte = RATE_7200;
      3'h1:    rate_byte = RATE_8000;
      3'h2:    rate_byte = RATE_8229;
      3'h3:    rate_byte = RATE_8400;
      3'h4:    rate_byte = RATE_9000;
      3'h5:    rate_byte = RATE_9600;
      3'h6:    rate_byte = RATE_10286;
      default: rate_byte = 8'h00;
    endcase
  endfunction : rate_byte

endpackage : sample_clock_pkg

// ---- verification/dev_model.sv ----
/*
  Behavioural model of the device control side: register file, frame
  timing and a watch on the host's write order.
  Assumes host pins synchronous to clock; resetPinN is its only reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dev_model (
  // Clock and device reset
  input  wire logic clock,
  input  wire logic resetPinN,
  // Frame link
  input  wire logic fcReq,
  input  wire logic serOut,
  output var logic  secFrameStart,
  output var logic  bitTick,
  output var logic  serIn
);
  logic [7:0]  regs [0:31];
  logic [15:0] sh;
  logic [3:0]  nb;
  logic [1:0]  ph;
  logic [4:0]  lastAddr, rdAddr;
  logic        inFrame, ratioLive, ruleBad;
  logic [12:0] wlog [$];
  int          wcyc [$];
  int          cyc = 0;
  wire  [15:0] word = {sh[14:0], serOut};
  wire         mapped = rdAddr >= 5'h06 && rdAddr <= 5'h0A;
  wire  [7:0]  rdByte = mapped ? regs[rdAddr] : 8'h00;
  wire  [8:0]  firstDivEff = {1'b0, regs[7]} + 9'h001;
  wire         firstBypass = regs[7] == 8'h00 && regs[8] == 8'h00;
  wire         ratioEff = ratioLive && regs[9] != 8'h00;
  wire  [4:0]  wa = word[12:8];

  always @(posedge clock) begin
    cyc = cyc + 1;
    secFrameStart <= 1'b0;
    bitTick <= 1'b0;
    // Released line shows no stale level
    serIn <= ~serIn;
    if (resetPinN !== 1'b1) begin
      for (int i = 0; i < 32; i++)
        regs[i] <= 8'h00;
      regs[6] <= 8'h10;
      serIn <= 1'b0;
      inFrame <= 1'b0;
      ratioLive <= 1'b0;
      ruleBad <= 1'b0;
      lastAddr <= 5'h00;
    end else if (!inFrame) begin
      if (fcReq === 1'b1 && !secFrameStart) begin
        secFrameStart <= 1'b1;
        inFrame <= 1'b1;
        ph <= 2'd0;
        nb <= 4'd0;
      end
    end else begin
      ph <= ph + 2'd1;
      if (ph == 2'd3) begin
        bitTick <= 1'b1;
        if (nb >= 4'd8)
          serIn <= rdByte[~nb[2:0]];
      end
      if (bitTick) begin
        sh <= word;
        nb <= nb + 4'd1;
        if (nb == 4'd7)
          rdAddr <= word[4:0];
        if (nb == 4'd15) begin
          inFrame <= 1'b0;
          if (!word[15]) begin
            regs[wa] <= word[7:0];
            wlog.push_back(word[12:0]);
            wcyc.push_back(cyc);
            lastAddr <= wa;
            if (wa == 5'h09)
              ratioLive <= regs[10][0];
            if (wa == 5'h08 && lastAddr != 5'h07)
              ruleBad <= 1'b1;
            if (wa == 5'h06 && word[7:0] == 8'h08 && (regs[7] == 8'h00
                || regs[8] == 8'h00 || regs[9] == 8'h00))
              ruleBad <= 1'b1;
            if (wa == 5'h06 && word[7:0] == 8'h18 && regs[9] != 8'h00)
              ruleBad <= 1'b1;
          end
        end
      end
    end
  end
endmodule : dev_model
`default_nettype wire

// ---- verification/sample_clock_host_tb.sv ----
/*
  Self-checking bench for the sample clock host controller.
  Assumes the device model answers every frame request.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_clock_host_tb;
  import sample_clock_pkg::*;
  localparam int LW = 20;
  localparam int MK = 20000;
  logic       clock, srst, clkEn, cmdValid, cmdRatioSelect, cmdReady;
  logic       donePulse, errPulse, settingValid, resetPinN, fcReq;
  logic       secFrameStart, bitTick, serOut, serIn;
  logic [7:0] cmdFirstDiv, cmdFirstMult, rdData;
  logic [2:0] cmdRate;
  logic [4:0] cmdAddr;
  op_e        cmdOp;
  mode_e      mode;
  int         errTotal, checks, cycles, lowCnt;

  sample_clock_host #(.LOCK_WAIT(LW), .MCLK_KHZ(MK)) i_sample_clock_host (
    .clock(clock), .srst(srst), .clkEn(clkEn), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdFirstDiv(cmdFirstDiv),
    .cmdFirstMult(cmdFirstMult), .cmdRatioSelect(cmdRatioSelect),
    .cmdRate(cmdRate), .cmdAddr(cmdAddr), .donePulse(donePulse),
    .errPulse(errPulse), .rdData(rdData), .mode(mode),
    .settingValid(settingValid), .resetPinN(resetPinN), .fcReq(fcReq),
    .secFrameStart(secFrameStart), .bitTick(bitTick), .serOut(serOut),
    .serIn(serIn));
  dev_model i_dev_model (.clock(clock), .resetPinN(resetPinN),
    .fcReq(fcReq), .serOut(serOut), .secFrameStart(secFrameStart),
    .bitTick(bitTick), .serIn(serIn));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic completeRun();
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : completeRun

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (resetPinN === 1'b0)
      lowCnt <= lowCnt + 1;
    if (cycles == 20000) begin
      errTotal++;
      $display("[ERR] %0t run timed out", $time);
      completeRun();
    end
  end

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      errTotal++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic runCmd(input op_e op, input logic [7:0] dv, ml,
      input logic rs, input logic [2:0] rt, input logic [4:0] ad,
      input logic expErr);
    int n;
    i_dev_model.wlog.delete();
    i_dev_model.wcyc.delete();
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdFirstDiv <= dv;
    cmdFirstMult <= ml;
    cmdRatioSelect <= rs;
    cmdRate <= rt;
    cmdAddr <= ad;
    @(posedge clock);
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (donePulse !== 1'b1 && errPulse !== 1'b1 && n < 3000);
    chk(errPulse === expErr && donePulse === !expErr, "command outcome");
  endtask : runCmd

  task automatic simple(input op_e op, input logic [4:0] ad, input logic e);
    runCmd(op, 8'h00, 8'h00, 1'b0, 3'h0, ad, e);
  endtask : simple

  task automatic chkWr(input int i, input logic [4:0] a, input logic [7:0] d);
    chk(i_dev_model.wlog.size() > i && i_dev_model.wlog[i] === {a, d},
        "write sequence");
  endtask : chkWr

  task automatic tReset();
    chk(cmdReady === 1'b1 && mode === MODE_RESET, "reset state");
    chk(settingValid === 1'b0 && resetPinN === 1'b1, "reset pins");
    chk(i_dev_model.firstBypass === 1'b1, "first stage bypassed");
    simple(OP_READ, REG_POWER_MODE, 1'b0);
    chk(rdData === 8'h10, "power mode after reset");
    simple(OP_RATE, 5'h00, 1'b1);
    simple(OP_SLEEP, 5'h00, 1'b1);
    simple(OP_WAKE, 5'h00, 1'b1);
    $display("test reset done");
  endtask : tReset

  task automatic tInit();
    runCmd(OP_INIT, 8'h7C, 8'h5F, 1'b0, 3'h7, 5'h00, 1'b1);
    runCmd(OP_INIT, 8'h8A, 8'h5F, 1'b0, 3'h0, 5'h00, 1'b1);
    runCmd(OP_INIT, 8'h7C, 8'h5F, 1'b0, 3'h0, 5'h00, 1'b0);
    chkWr(0, REG_FIRST_DIV, 8'h7C);
    chkWr(1, REG_FIRST_MULT, 8'h5F);
    chkWr(2, REG_RATIO_SELECT, 8'h00);
    chkWr(3, REG_SECOND_RATIO, 8'h11);
    chkWr(4, REG_POWER_MODE, 8'h80);
    chk(i_dev_model.wcyc[4] - i_dev_model.wcyc[3] > LW + 64, "lock wait");
    chk(i_dev_model.firstDivEff === 9'h07D, "first divider plus one");
    chk(i_dev_model.firstBypass === 1'b0, "first stage in use");
    chk(mode === MODE_NORMAL && settingValid === 1'b1, "normal");
    simple(OP_READ, REG_FIRST_MULT, 1'b0);
    chk(rdData === 8'h5F, "read back multiplier");
    simple(OP_READ, 5'h1F, 1'b0);
    chk(rdData === 8'h00, "unmapped read");
    $display("test init done");
  endtask : tInit

  task automatic tFreeze();
    @(posedge clock);
    clkEn <= 1'b0;
    cmdValid <= 1'b1;
    cmdOp <= OP_WAKE;
    repeat (3) @(posedge clock);
    chk(errPulse === 1'b0 && cmdReady === 1'b1, "frozen by enable");
    cmdValid <= 1'b0;
    clkEn <= 1'b1;
    @(posedge clock);
    chk(errPulse === 1'b0 && mode === MODE_NORMAL, "nothing taken");
    $display("test freeze done");
  endtask : tFreeze

  task automatic tRates();
    int n2[7] = '{2, 9, 7, 6, 4, 3, 7};
    int m2[7] = '{2, 10, 8, 7, 5, 4, 10};
    for (int i = 0; i < 7; i++) begin
      runCmd(OP_RATE, 8'h00, 8'h00, 1'b0, 3'(i), 5'h00, 1'b0);
      chk(i_dev_model.wlog.size() == 1, "one write per rate");
      chkWr(0, REG_SECOND_RATIO, {4'(n2[i] - 1), 4'(m2[i] - 1)});
    end
    $display("test rates done");
  endtask : tRates

  task automatic tSleep();
    int low0;
    simple(OP_SLEEP, 5'h00, 1'b0);
    chkWr(0, REG_POWER_MODE, 8'h08);
    chk(mode === MODE_SLEEP, "sleep mode");
    simple(OP_READ, REG_POWER_MODE, 1'b1);
    simple(OP_RATE, 5'h00, 1'b1);
    chk(i_dev_model.ruleBad === 1'b0, "sleep write order");
    low0 = lowCnt;
    simple(OP_WAKE, 5'h00, 1'b0);
    chk(lowCnt - low0 == RST_PULSE_CYCLES + 1, "wake pulse");
    chk(mode === MODE_RESET && settingValid === 1'b0, "wake state");
    $display("test sleep done");
  endtask : tSleep

  task automatic tDeep();
    runCmd(OP_INIT, 8'h89, 8'h01, 1'b1, 3'h6, 5'h00, 1'b0);
    chkWr(2, REG_RATIO_SELECT, 8'h01);
    chkWr(3, REG_SECOND_RATIO, 8'h69);
    chk(i_dev_model.ratioEff === 1'b1, "ratio bit live");
    simple(OP_DEEP, 5'h00, 1'b0);
    chkWr(0, REG_SECOND_RATIO, 8'h00);
    chkWr(1, REG_POWER_MODE, 8'h18);
    chk(mode === MODE_DEEP, "deep mode");
    chk(i_dev_model.ratioEff === 1'b0, "ratio cancelled");
    simple(OP_DEEP, 5'h00, 1'b1);
    runCmd(OP_INIT, 8'h7C, 8'h5F, 1'b0, 3'h0, 5'h00, 1'b1);
    chk(i_dev_model.ruleBad === 1'b0, "device write order");
    simple(OP_WAKE, 5'h00, 1'b0);
    chk(mode === MODE_RESET, "deep wake state");
    $display("test deep done");
  endtask : tDeep

  initial begin
    srst = 1'b1;
    clkEn = 1'b1;
    cmdValid = 1'b0;
    cmdOp = OP_INIT;
    cmdFirstDiv = 8'h00;
    cmdFirstMult = 8'h00;
    cmdRatioSelect = 1'b0;
    cmdRate = 3'h0;
    cmdAddr = 5'h00;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    tReset();
    tInit();
    tFreeze();
    tRates();
    tSleep();
    tDeep();
    completeRun();
  end
endmodule : sample_clock_host_tb
`default_nettype wire
